// >>> rtl/i2c_nvmem_slave.sv
// Two-wire slave front end and 512 x 8 storage array
// Function
// - 512 bytes, contents survive without backup
// - Slave only, never drives the clock
// - Data changes only while clock low
// - Sample on rising, drive on falling
// - Data line is open drain, bidirectional
// - Start is data falling, clock high
// - Stop is data rising, clock high
// - Stop during read ends read, standby
// - Stop during write ends write, standby
// - No programming wait after write stop
// - Answer only when select bits match
// - Select mismatch means no operation
// - Open select pins read as low
// - Write lock high refuses every write
// - Reads allowed whatever write lock level
// - Open write lock pin reads low
// - Receiver pulls data low on ninth clock
// - Device word: type, select, high bit, rw
// - Wrong type or select stays in standby
// - Address advances per byte, wraps to zero
`timescale 1ns/1ps
module i2c_nvmem_slave #(
  parameter logic [3:0] TYPE_CODE = 4'h5  // Arbitrary value
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Serial bus
  input  wire logic sclPin,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  // Straps and write lock
  input  wire logic select_pin_low,
  input  wire logic select_pin_high,
  input  wire logic writeLockPin
);

  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic [1:0] wlSync_q;
  logic [1:0] selLoSync_q;
  logic [1:0] selHiSync_q;
  logic       sclPrev_q;
  logic       sdaPrev_q;

  logic sclS;
  logic sdaS;
  logic wlS;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;

  nvmem_pkg::slvState_t state_q;
  logic [3:0]                      bitCnt_q;
  logic [7:0]                      shift_q;
  logic [7:0]                      tx_q;
  logic                            hiBit_q;
  logic                            sdaOe_q;
  logic                            masterNack_q;
  logic [nvmem_pkg::ADDR_W-1:0]    addr_q;
  logic [nvmem_pkg::DATA_W-1:0]    mem [nvmem_pkg::MEM_DEPTH];

  logic                            byteDone;
  logic                            devMatch;
  logic [nvmem_pkg::ADDR_W-1:0]    readAddr;
  logic                            readLoad;
  logic                            wrByteEnd;
  logic                            pushValid;
  logic                            pushReady;
  nvmem_pkg::wrEntry_t             pushEntry;
  logic                            popValid;
  logic                            popReady;
  nvmem_pkg::wrEntry_t             popEntry;

  // Two-stage synchronisers; pads carry the pull-downs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclSync_q   <= 2'h3;
      sdaSync_q   <= 2'h3;
      wlSync_q    <= 2'h0;
      selLoSync_q <= 2'h0;
      selHiSync_q <= 2'h0;
    end else begin
      sclSync_q   <= {sclSync_q[0], sclPin};
      sdaSync_q   <= {sdaSync_q[0], sdaIn};
      wlSync_q    <= {wlSync_q[0], writeLockPin};
      selLoSync_q <= {selLoSync_q[0], select_pin_low};
      selHiSync_q <= {selHiSync_q[0], select_pin_high};
    end
  end

  assign sclS = sclSync_q[1];
  assign sdaS = sdaSync_q[1];
  assign wlS  = wlSync_q[1];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  // Edges of the master's clock pace every bit
  assign sclRise  = sclS && !sclPrev_q;
  assign sclFall  = !sclS && sclPrev_q;
  assign startDet = sclS && sclPrev_q && sdaPrev_q && !sdaS;
  assign stopDet  = sclS && sclPrev_q && !sdaPrev_q && sdaS;

  assign byteDone = (bitCnt_q == nvmem_pkg::BITS_PER_BYTE);

  // Device word: type, two select bits, high address bit, direction
  assign devMatch =
    (shift_q[nvmem_pkg::DEV_TYPE_MSB:nvmem_pkg::DEV_TYPE_LSB] == TYPE_CODE) &&
    (shift_q[nvmem_pkg::DEV_SEL_HI] == selHiSync_q[1]) &&
    (shift_q[nvmem_pkg::DEV_SEL_LO] == selLoSync_q[1]);

  // Current-address reads take the high bit from the device word
  assign readAddr = (state_q == nvmem_pkg::ST_DEV_ACK) ?
                    {hiBit_q, addr_q[7:0]} : addr_q;
  assign readLoad = sclFall && !startDet && !stopDet &&
                    (((state_q == nvmem_pkg::ST_DEV_ACK) && shift_q[nvmem_pkg::DEV_RW]) ||
                     ((state_q == nvmem_pkg::ST_RDATA_ACK) && !masterNack_q));
  assign wrByteEnd = sclFall && (state_q == nvmem_pkg::ST_WDATA) && byteDone;

  // Locked writes are acknowledged but never buffered
  assign pushValid      = wrByteEnd && !wlS;
  assign pushEntry.addr = addr_q;
  assign pushEntry.data = shift_q;

  // Main sequencer; start and stop override any bit activity
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= nvmem_pkg::ST_IDLE;
    end else if (startDet) begin
      state_q <= nvmem_pkg::ST_DEV;
    end else if (stopDet) begin
      state_q <= nvmem_pkg::ST_IDLE;
    end else if (sclFall) begin
      unique case (state_q)
        nvmem_pkg::ST_IDLE: begin
          state_q <= nvmem_pkg::ST_IDLE;
        end
        nvmem_pkg::ST_DEV: begin
          if (byteDone) begin
            state_q <= devMatch ? nvmem_pkg::ST_DEV_ACK : nvmem_pkg::ST_IDLE;
          end
        end
        nvmem_pkg::ST_DEV_ACK: begin
          state_q <= shift_q[nvmem_pkg::DEV_RW] ? nvmem_pkg::ST_RDATA : nvmem_pkg::ST_ADDR;
        end
        nvmem_pkg::ST_ADDR: begin
          if (byteDone) begin
            state_q <= nvmem_pkg::ST_ADDR_ACK;
          end
        end
        nvmem_pkg::ST_ADDR_ACK: begin
          state_q <= nvmem_pkg::ST_WDATA;
        end
        nvmem_pkg::ST_WDATA: begin
          if (byteDone) begin
            state_q <= nvmem_pkg::ST_WDATA_ACK;
          end
        end
        nvmem_pkg::ST_WDATA_ACK: begin
          state_q <= nvmem_pkg::ST_WDATA;
        end
        nvmem_pkg::ST_RDATA: begin
          if (byteDone) begin
            state_q <= nvmem_pkg::ST_RDATA_ACK;
          end
        end
        nvmem_pkg::ST_RDATA_ACK: begin
          state_q <= masterNack_q ? nvmem_pkg::ST_IDLE : nvmem_pkg::ST_RDATA;
        end
      endcase
    end
  end

  // Bit counter: counts received or sent bits of the current byte
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bitCnt_q <= nvmem_pkg::BIT_CNT_RESET;
    end else if (startDet || stopDet) begin
      bitCnt_q <= nvmem_pkg::BIT_CNT_RESET;
    end else if (sclRise && !byteDone &&
                 (state_q inside {nvmem_pkg::ST_DEV, nvmem_pkg::ST_ADDR,
                                  nvmem_pkg::ST_WDATA, nvmem_pkg::ST_RDATA})) begin
      bitCnt_q <= bitCnt_q + 4'h1;
    end else if (sclFall && byteDone) begin
      bitCnt_q <= nvmem_pkg::BIT_CNT_RESET;
    end
  end

  // Incoming bits are taken on the rising edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shift_q <= nvmem_pkg::BYTE_RESET;
    end else if (sclRise && !byteDone &&
                 (state_q inside {nvmem_pkg::ST_DEV, nvmem_pkg::ST_ADDR,
                                  nvmem_pkg::ST_WDATA})) begin
      shift_q <= {shift_q[6:0], sdaS};
    end
  end

  // Master's acknowledge after each read byte
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      masterNack_q <= 1'b1;
    end else if (sclRise && (state_q == nvmem_pkg::ST_RDATA_ACK)) begin
      masterNack_q <= sdaS;
    end
  end

  // Upper address bit from the device word
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hiBit_q <= 1'b0;
    end else if (sclFall && (state_q == nvmem_pkg::ST_DEV) && byteDone && devMatch) begin
      hiBit_q <= shift_q[nvmem_pkg::DEV_ADDR_HI];
    end
  end

  // Address pointer holds the next location to touch
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_q <= nvmem_pkg::ADDR_RESET;
    end else if (sclFall && (state_q == nvmem_pkg::ST_ADDR) && byteDone) begin
      addr_q <= {hiBit_q, shift_q};
    end else if (wrByteEnd && (pushReady || wlS)) begin
      addr_q <= addr_q + 9'h001;
    end else if (readLoad) begin
      addr_q <= readAddr + 9'h001;
    end
  end

  // Transmit byte is fetched on the falling edge that starts it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_q <= nvmem_pkg::BYTE_RESET;
    end else if (readLoad) begin
      tx_q <= mem[readAddr];
    end
  end

  // Data line drive: only ever pulled low, updated on falling edges
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sdaOe_q <= 1'b0;
    end else if (startDet || stopDet) begin
      sdaOe_q <= 1'b0;
    end else if (sclFall) begin
      unique case (state_q)
        nvmem_pkg::ST_DEV: begin
          sdaOe_q <= byteDone && devMatch;
        end
        nvmem_pkg::ST_ADDR: begin
          sdaOe_q <= byteDone;
        end
        nvmem_pkg::ST_WDATA: begin
          // Full buffer answers not-acknowledge unless write lock is high
          sdaOe_q <= byteDone && (pushReady || wlS);
        end
        nvmem_pkg::ST_DEV_ACK: begin
          sdaOe_q <= shift_q[nvmem_pkg::DEV_RW] && !mem[readAddr][7];
        end
        nvmem_pkg::ST_RDATA: begin
          // Release for the master's acknowledge, else next bit
          sdaOe_q <= !byteDone && (bitCnt_q != 4'h0) &&
                     !tx_q[3'h7 - bitCnt_q[2:0]];
        end
        nvmem_pkg::ST_RDATA_ACK: begin
          sdaOe_q <= !masterNack_q && !mem[readAddr][7];
        end
        default: begin
          sdaOe_q <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: the pad only ever sinks
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_q;

  // Buffered writes land in the array with no programming wait
  wr_fifo #(
    .WIDTH ($bits(nvmem_pkg::wrEntry_t)),
    .DEPTH (nvmem_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushEntry),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popEntry)
  );

  // Read fetch owns the array port, so draining pauses for it
  assign popReady = !readLoad;

  // Storage is never cleared by reset
  always_ff @(posedge mclk) begin
    if (popValid && popReady) begin
      mem[popEntry.addr] <= popEntry.data;
    end
  end

  property p_start_to_dev;
    @(posedge mclk) disable iff (!rst_n)
    startDet |=> (state_q == nvmem_pkg::ST_DEV) && (bitCnt_q == 4'h0) && !sdaOe;
  endproperty
  a_start_to_dev: assert property (p_start_to_dev) else $error("start not taken");
  property p_stop_to_idle;
    @(posedge mclk) disable iff (!rst_n)
    stopDet && !startDet |=> (state_q == nvmem_pkg::ST_IDLE) && !sdaOe;
  endproperty
  a_stop_to_idle: assert property (p_stop_to_idle) else $error("stop not honoured");
  property p_drive_changes_scl_low;
    @(posedge mclk) disable iff (!rst_n)
    $changed(sdaOe) |-> !$past(sclS) || $past(startDet) || $past(stopDet);
  endproperty
  a_drive_changes_scl_low: assert property (p_drive_changes_scl_low)
    else $error("drive while scl high");
  property p_locked_no_push;
    @(posedge mclk) disable iff (!rst_n)
    wrByteEnd && wlS |-> !pushValid ##1 (addr_q == $past(addr_q) + 9'h001);
  endproperty
  a_locked_no_push: assert property (p_locked_no_push) else $error("locked byte stored");
  property p_mismatch_standby;
    @(posedge mclk) disable iff (!rst_n)
    sclFall && !startDet && !stopDet && (state_q == nvmem_pkg::ST_DEV) && byteDone && !devMatch
      |=> (state_q == nvmem_pkg::ST_IDLE) && !sdaOe;
  endproperty
  a_mismatch_standby: assert property (p_mismatch_standby) else $error("mismatch acked");
  property p_ack_low;
    @(posedge mclk) disable iff (!rst_n)
    $changed(state_q) && (state_q inside {nvmem_pkg::ST_DEV_ACK, nvmem_pkg::ST_ADDR_ACK})
      |-> sdaOe;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven");
  property p_addr_wrap;
    @(posedge mclk) disable iff (!rst_n)
    pushValid && pushReady && (addr_q == nvmem_pkg::ADDR_LAST) |=> addr_q == nvmem_pkg::ADDR_RESET;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("address did not wrap");
  property p_idle_released;
    @(posedge mclk) disable iff (!rst_n)
    (state_q == nvmem_pkg::ST_IDLE) && $past(state_q == nvmem_pkg::ST_IDLE) |-> !sdaOe;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("line held in standby");
  property p_drain_writes;
    @(posedge mclk) disable iff (!rst_n)
    popValid && !readLoad |=> mem[$past(popEntry.addr)] == $past(popEntry.data);
  endproperty
  a_drain_writes: assert property (p_drain_writes) else $error("buffered byte lost");

endmodule

// >>> rtl/nvmem_pkg.sv
// Shared constants and types for the two-wire byte memory slave
package nvmem_pkg;

  // Array geometry
  localparam int MEM_DEPTH  = 512;
  localparam int ADDR_W     = 9;
  localparam int DATA_W     = 8;

  // Serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;

  // Device word field positions
  localparam int DEV_TYPE_MSB = 7;
  localparam int DEV_TYPE_LSB = 4;
  localparam int DEV_SEL_HI   = 3;
  localparam int DEV_SEL_LO   = 2;
  localparam int DEV_ADDR_HI  = 1;
  localparam int DEV_RW       = 0;

  // Reset values and last address
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
  localparam logic [ADDR_W-1:0] ADDR_LAST  = 9'h1ff;
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;

  // Write buffer depth
  localparam int FIFO_DEPTH = 8;

  // One buffered write: target location and byte
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wrEntry_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEV,
    ST_DEV_ACK,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } slvState_t;

endpackage

// >>> rtl/wr_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module wr_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wrPtr_q;
  logic [PW:0]      rdPtr_q;
  logic             full;
  logic             empty;
  logic             doPush;
  logic             doPop;

  assign empty    = (wrPtr_q == rdPtr_q);
  assign full     = (wrPtr_q[PW-1:0] == rdPtr_q[PW-1:0]) && (wrPtr_q[PW] != rdPtr_q[PW]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = store[rdPtr_q[PW-1:0]];
  assign doPush   = inValid && !full;
  assign doPop    = outReady && !empty;

  always_ff @(posedge mclk) begin
    if (doPush) begin
      store[wrPtr_q[PW-1:0]] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
    end else if (doPush) begin
      wrPtr_q <= wrPtr_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdPtr_q <= '0;
    end else if (doPop) begin
      rdPtr_q <= rdPtr_q + 1'b1;
    end
  end

  property p_full_refuses;
    @(posedge mclk) disable iff (!rst_n)
    full |-> !inReady ##1 $stable(wrPtr_q);
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("fifo accepted while full");

endmodule

// >>> verification/i2c_master_model.sv
// Two-wire bus master model driving clock and open-drain data
`timescale 1ns/1ps
module i2c_master_model (
  // Clock
  input  wire logic mclk,
  // Bus
  output logic      scl,
  output logic      mOe,
  input  wire logic sdaWire
);
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    mOe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Low phase 5 cycles, high phase 3, data set early in low phase
  task automatic bitTx(input logic b, output logic r);
    tick(2);
    mOe <= !b;
    tick(3);
    scl <= 1'b1;
    tick(2);
    r = sdaWire;
    tick(1);
    scl <= 1'b0;
  endtask

  // Also serves as repeated start
  task automatic start();
    tick(4);
    mOe <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(2);
    mOe <= 1'b1;
    tick(2);
    scl <= 1'b0;
  endtask

  task automatic stop();
    tick(2);
    mOe <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    mOe <= 1'b0;
    tick(4);
  endtask

  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitTx(d[i], r);
    end
    bitTx(1'b1, r);
    ack = !r;
  endtask

  // Master acknowledges every byte but the last
  task automatic readByte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitTx(1'b1, r);
      d[i] = r;
    end
    bitTx(last, r);
  endtask
endmodule

// >>> verification/i2c_nvmem_slave_bench.sv
// Self-checking bench for the two-wire byte memory slave
`timescale 1ns/1ps
module i2c_nvmem_slave_bench;
  localparam logic [3:0] TYPE_CODE = 4'h5; // Arbitrary value

  logic                          mclk       = 1'b0;
  logic                          rst_n      = 1'b0;
  logic [1:0]                    sel        = 2'h0;
  logic                          lock       = 1'b0;
  logic                          oePrev     = 1'b0;
  logic [31:0]                   seed       = 32'h0000004f;
  logic                          scl;
  logic                          mOe;
  logic                          sdaOut;
  logic                          sdaOe;
  logic                          sdaWire;
  logic [7:0]                    refMem [nvmem_pkg::MEM_DEPTH];
  logic [nvmem_pkg::ADDR_W-1:0]  nextA;
  int                            n_mismatch = 0;
  int                            cmp_count  = 0;

  always #12.5 mclk = ~mclk;

  // Pull-up wins unless someone pulls low
  assign sdaWire = !(sdaOe | mOe);

  i2c_nvmem_slave #(.TYPE_CODE(TYPE_CODE)) i2c_nvmem_slave_i (
    .mclk(mclk), .rst_n(rst_n), .sclPin(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .select_pin_low(sel[0]), .select_pin_high(sel[1]),
    .writeLockPin(lock)
  );

  i2c_master_model i2c_master_model_i (
    .mclk(mclk), .scl(scl), .mOe(mOe), .sdaWire(sdaWire)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] dev(input logic [1:0] s, input logic a8, input logic rw);
    return {TYPE_CODE, s, a8, rw};
  endfunction

  task automatic checkBit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Device output may only move while the bus clock is low
  always @(posedge mclk) begin
    if (rst_n && scl && sdaOe !== oePrev) checkBit("drive edge", oePrev, sdaOe);
    oePrev <= sdaOe;
  end

  task automatic setAddr(input logic [8:0] a);
    logic ack;
    i2c_master_model_i.start();
    i2c_master_model_i.writeByte(dev(sel, a[8], 1'b0), ack);
    checkBit("dev ack", 1'b1, ack);
    i2c_master_model_i.writeByte(a[7:0], ack);
    checkBit("addr ack", 1'b1, ack);
  endtask

  task automatic wrBurst(input logic [8:0] a, input int n);
    logic       ack;
    logic [7:0] d;
    setAddr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'(rnd());
      i2c_master_model_i.writeByte(d, ack);
      checkBit("data ack", 1'b1, ack);
      if (!lock) refMem[a] = d;
      a++;
    end
    i2c_master_model_i.stop();
    checkBit("release", 1'b0, sdaOe);
    checkBit("drain level", 1'b0, sdaOut);
  endtask

  task automatic rdBurst(input logic [8:0] a, input int n);
    logic       ack;
    logic [7:0] d;
    setAddr(a);
    i2c_master_model_i.start();
    i2c_master_model_i.writeByte(dev(sel, a[8], 1'b1), ack);
    checkBit("read ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      i2c_master_model_i.readByte(i == n - 1, d);
      checkByte("read data", refMem[a], d);
      a++;
    end
    i2c_master_model_i.stop();
    checkBit("release", 1'b0, sdaOe);
    nextA = a;
  endtask

  task automatic curRead();
    logic       ack;
    logic [7:0] d;
    i2c_master_model_i.start();
    i2c_master_model_i.writeByte(dev(sel, nextA[8], 1'b1), ack);
    checkBit("current ack", 1'b1, ack);
    i2c_master_model_i.readByte(1'b1, d);
    checkByte("current data", refMem[nextA], d);
    i2c_master_model_i.stop();
  endtask

  // Every select code against random straps, then a wrong type code
  task automatic selTest();
    logic ack;
    @(posedge mclk);
    sel <= 2'(rnd());
    repeat (4) @(posedge mclk);
    for (int k = 0; k < 5; k++) begin
      i2c_master_model_i.start();
      if (k < 4) i2c_master_model_i.writeByte(dev(2'(k), 1'b0, 1'b0), ack);
      else i2c_master_model_i.writeByte({~TYPE_CODE, sel, 2'h0}, ack);
      checkBit("select ack", k < 4 && k == int'(sel), ack);
      i2c_master_model_i.stop();
    end
  endtask

  initial begin
    logic       ack;
    logic [8:0] a;
    repeat (2) @(posedge mclk);
    checkBit("reset release", 1'b0, sdaOe);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    wrBurst(9'h1fe, 4);
    rdBurst(9'h1fe, 3);
    curRead();
    $display("test wrap done");
    // Byte cut short by stop must not land
    setAddr(9'h1ff);
    i2c_master_model_i.writeByte(8'h3c, ack);
    checkBit("data ack", 1'b1, ack);
    refMem[9'h1ff] = 8'h3c;
    for (int i = 0; i < 3; i++) begin
      i2c_master_model_i.bitTx(1'b0, ack);
    end
    i2c_master_model_i.stop();
    rdBurst(9'h1ff, 2);
    $display("test partial done");
    selTest();
    $display("test select done");
    lock <= 1'b1;
    wrBurst(9'h1fe, 2);
    rdBurst(9'h1fe, 2);
    lock <= 1'b0;
    $display("test lock done");
    for (int i = 0; i < 6; i++) begin
      a = 9'(rnd());
      wrBurst(a, 3);
      rdBurst(a, 3);
    end
    $display("test random done");
    complete_run();
  end

  // About five times the expected length of the run
  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    $display("ERROR watchdog expected finish seen hang");
    complete_run();
  end
endmodule
